// ==== hdl/pia_arbiter.sv ====
`timescale 1ns/100ps
module pia_arbiter (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [pia_pkg::NUM_VEC-1:0] irq_req,
  input wire pia_pkg::pia_slot_t [pia_pkg::NUM_SLOT-1:0] lvl1_slot,
  input wire pia_pkg::pia_slot_t [pia_pkg::NUM_SLOT-1:0] lvl2_slot,
  input wire logic [pia_pkg::LVL_W-1:0] core_level,
  input wire logic [pia_pkg::ADDR_W-1:0] vector_base,
  input wire logic [pia_pkg::OPC_W-1:0] last_vec_opcode,
  output pia_pkg::pia_grant_t grant
);
  import pia_pkg::*;

  // ==========================================================
  // slot decoding
  // one-hot mask of the source a slot names; zero when disabled
  function automatic logic [NUM_VEC-1:0] slot_mask(input pia_slot_t s);
    logic [NUM_VEC-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_VEC; i++) begin
      if (s.en && (s.vec == VEC_W'(i))) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  logic [NUM_SLOT-1:0][NUM_VEC-1:0] m1;
  logic [NUM_SLOT-1:0][NUM_VEC-1:0] m2;
  logic [NUM_VEC-1:0] l1_mask;
  logic [NUM_VEC-1:0] l2_mask;
  logic [NUM_VEC-1:0] l0_mask;

  generate
    for (genvar g = 0; g < NUM_SLOT; g++) begin : g_slot
      assign m1[g] = slot_mask(lvl1_slot[g]);
      assign m2[g] = slot_mask(lvl2_slot[g]);
    end
  endgenerate

  // level 2 claims a source first so the two sets never overlap
  always_comb begin
    l2_mask = '0;
    l1_mask = '0;
    for (int s = 0; s < NUM_SLOT; s++) begin
      l2_mask = l2_mask | m2[s];
      l1_mask = l1_mask | m1[s];
    end
    l1_mask = l1_mask & ~l2_mask;
  end

  // anything not claimed stays at level 0; the slots are inputs and nrst does not clear them
  assign l0_mask = ~(l1_mask | l2_mask);

  // ==========================================================
  // per-level encoders
  logic [2:0] hit;
  logic [2:0][VEC_W-1:0] idx;
  logic [2:0][NUM_VEC-1:0] lreq;

  assign lreq[0] = irq_req & l0_mask;
  assign lreq[1] = irq_req & l1_mask;
  assign lreq[2] = irq_req & l2_mask;

  generate
    for (genvar l = 0; l < 3; l++) begin : g_lvl
      pia_prio_enc u_enc (
        .req (lreq[l]),
        .hit (hit[l]),
        .idx (idx[l])
      );
    end
  endgenerate

  // ==========================================================
  // level selection against the core's acceptance level
  logic win_hit;
  logic [LVL_W-1:0] win_lvl;
  logic [VEC_W-1:0] win_vec;

  always_comb begin
    win_hit = 1'b0;
    win_lvl = LVL0;
    win_vec = VEC_RST;
    if (hit[2]) begin
      win_lvl = LVL2;
      win_vec = idx[2];
      win_hit = 1'b1;
    end else if (hit[1]) begin
      win_lvl = LVL1;
      win_vec = idx[1];
      win_hit = 1'b1;
    end else if (hit[0]) begin
      win_lvl = LVL0;
      win_vec = idx[0];
      win_hit = 1'b1;
    end
    // a masked top level hides lower ones too, since they rank below it
    if (win_lvl < core_level) begin
      win_hit = 1'b0;
    end
  end

  // ==========================================================
  // fast-interrupt qualification of the last user vector
  logic is_call;
  assign is_call =
    ((last_vec_opcode & SUBROUTINE_JUMP_MASK) == SUBROUTINE_JUMP_OPCODE) ||
    ((last_vec_opcode & SUBROUTINE_BRANCH_MASK) == SUBROUTINE_BRANCH_OPCODE);

  // ==========================================================
  // registered answer to the core, one cycle behind the inputs
  logic [ADDR_W-1:0] addr_next;
  assign addr_next = vector_base +
    (ADDR_W'(win_vec) << VEC_STRIDE_SHIFT);

  pia_grant_t grant_reg;
  pia_grant_t grant_next;

  always_comb begin
    grant_next.pending = win_hit;
    grant_next.level = win_hit ? win_lvl : LVL0;
    grant_next.vec = win_hit ? win_vec : VEC_RST;
    grant_next.addr = win_hit ? addr_next : ADDR_RST;
    grant_next.fast = win_hit && (win_vec == LAST_USER_VECTOR) &&
      !is_call;
  end

  // output register; inputs are synchronous to ref_clk already
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      grant_reg <= '0;
    end else begin
      grant_reg <= grant_next;
    end
  end

  assign grant = grant_reg;

  // ==========================================================
  // checking helpers: last cycle's inputs and level masks
  logic [NUM_VEC-1:0] req_reg;
  logic [NUM_VEC-1:0] l1_reg;
  logic [NUM_VEC-1:0] l2_reg;
  logic [LVL_W-1:0] core_reg;
  logic [ADDR_W-1:0] base_reg;
  logic call_reg;
  logic [NUM_VEC-1:0] lvl_q;
  logic [NUM_VEC-1:0] below_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_reg <= '0;
      l1_reg <= '0;
      l2_reg <= '0;
      core_reg <= LVL0;
      base_reg <= ADDR_RST;
      call_reg <= 1'b0;
    end else begin
      req_reg <= irq_req;
      l1_reg <= l1_mask;
      l2_reg <= l2_mask;
      core_reg <= core_level;
      base_reg <= vector_base;
      call_reg <= is_call;
    end
  end

  // sources of the granted level and vector numbers below the granted vector
  always_comb begin
    lvl_q = (grant_reg.level == LVL2) ? l2_reg :
      (grant_reg.level == LVL1) ? l1_reg : ~(l1_reg | l2_reg);
    below_q = '0;
    for (int i = 0; i < NUM_VEC; i++) begin
      below_q[i] = (VEC_W'(i) < grant_reg.vec);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_any_req_open;
    (|irq_req) && (core_level == LVL0);
  endsequence

  sequence s_granted;
    grant.pending;
  endsequence

  open_req_grant_a: assert property (s_any_req_open |=> s_granted)
    else $error("open request not flagged to the core");

  grant_addr_a: assert property (grant.pending |->
    grant.addr == base_reg + (ADDR_W'(grant.vec) << VEC_STRIDE_SHIFT))
    else $error("vector address does not match granted vector");

  level1_member_a: assert property ((grant.pending &&
    grant.level == LVL1) |-> l1_reg[grant.vec])
    else $error("level 1 grant for a source not in a level 1 slot");

  level2_member_a: assert property ((grant.pending &&
    grant.level == LVL2) |-> l2_reg[grant.vec] && !l1_reg[grant.vec])
    else $error("level 2 grant for a source not in a level 2 slot");

  unassigned_level0_a: assert property ((grant.pending &&
    !l1_reg[grant.vec] && !l2_reg[grant.vec]) |-> grant.level == LVL0)
    else $error("unassigned source granted above level 0");

  lowest_wins_a: assert property (grant.pending |->
    req_reg[grant.vec] && !(|(req_reg & lvl_q & below_q)))
    else $error("a lower pending vector at the same level was skipped");

  fast_vector_a: assert property (grant.fast |->
    grant.pending && grant.vec == LAST_USER_VECTOR && !call_reg)
    else $error("fast flag without a qualifying last user vector");

  fast_missed_a: assert property ((grant.pending &&
    grant.vec == LAST_USER_VECTOR && !call_reg) |-> grant.fast)
    else $error("last user vector not marked fast");

  // a level 0 grant also proves that no level 1 request was pending
  accept_level_a: assert property (grant.pending |->
    grant.level >= core_reg &&
    !(grant.level < LVL2 && |(req_reg & l2_reg)) &&
    !(grant.level == LVL0 && |(req_reg & l1_reg)))
    else $error("grant below acceptance level or higher level ignored");

endmodule

// ==== hdl/pia_pkg.sv ====
// Summary of operation
// - arbitrate pending requests, flag the core and give the vector address
// - three configuration slots put up to three sources at level 1
// - three further slots put up to three other sources at level 2
// - a source sits at level 0 unless an enabled slot input assigns it higher; reset does not clear the slots
// - within a level the smallest pending vector number wins
// - vector 50 is fast unless its stored opcode is a subroutine call
package pia_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned NUM_VEC = 51;
  localparam int unsigned VEC_W = 6;
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned OPC_W = 16;
  localparam int unsigned LVL_W = 2;
  localparam int unsigned NUM_SLOT = 3;

  // ==========================================================
  // vector and level constants
  localparam logic [VEC_W-1:0] LAST_USER_VECTOR = 6'h32;
  localparam logic [LVL_W-1:0] LVL0 = 2'h0;
  localparam logic [LVL_W-1:0] LVL1 = 2'h1;
  localparam logic [LVL_W-1:0] LVL2 = 2'h2;
  // each vector slot holds two program words
  localparam int unsigned VEC_STRIDE_SHIFT = 1;

  // ==========================================================
  // opcode patterns for the fast-interrupt test
  localparam logic [OPC_W-1:0] SUBROUTINE_JUMP_OPCODE = 16'hE2C0;
  localparam logic [OPC_W-1:0] SUBROUTINE_JUMP_MASK = 16'hFFC0;
  localparam logic [OPC_W-1:0] SUBROUTINE_BRANCH_OPCODE = 16'hE440;
  localparam logic [OPC_W-1:0] SUBROUTINE_BRANCH_MASK = 16'hFFC0;

  // ==========================================================
  // reset values
  localparam logic [VEC_W-1:0] VEC_RST = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic en;
    logic [VEC_W-1:0] vec;
  } pia_slot_t;

  typedef struct packed {
    logic pending;
    logic fast;
    logic [LVL_W-1:0] level;
    logic [VEC_W-1:0] vec;
    logic [ADDR_W-1:0] addr;
  } pia_grant_t;

endpackage

// ==== hdl/pia_prio_enc.sv ====
`timescale 1ns/100ps
// lowest-index-wins encoder over one level's requests
module pia_prio_enc (
  input wire logic [pia_pkg::NUM_VEC-1:0] req,
  output logic hit,
  output logic [pia_pkg::VEC_W-1:0] idx
);
  import pia_pkg::*;

  // ==========================================================
  // scan downward so the last match is the smallest index
  always_comb begin
    hit = 1'b0;
    idx = VEC_RST;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        hit = 1'b1;
        idx = VEC_W'(i);
      end
    end
  end

endmodule

// ==== testbench/pia_core_model.sv ====
`timescale 1ns/100ps
// ==========================================
// core side: acceptance level and the word stored at vector 50
module pia_core_model (
  input wire logic ref_clk,
  input wire pia_pkg::pia_grant_t grant,
  output logic [pia_pkg::LVL_W-1:0] core_level,
  output logic [pia_pkg::OPC_W-1:0] last_vec_opcode
);
  import pia_pkg::*;
  int n_taken = 0;
  // core starts open to every level with a plain word at vector 50
  initial begin
    core_level = LVL0;
    last_vec_opcode = 16'h0000;
  end
  // the core takes whatever is pending; no ack, the grant simply stands
  always @(posedge ref_clk) begin
    if (grant.pending === 1'b1)
      n_taken <= n_taken + 1;
  end
  // called just after a clock edge, so the arbiter samples a settled value
  task automatic set(input logic [LVL_W-1:0] l, input logic [OPC_W-1:0] o);
    core_level = l;
    last_vec_opcode = o;
  endtask
endmodule

// ==== testbench/priority_interrupt_arbiter_tb.sv ====
`timescale 1ns/100ps
module priority_interrupt_arbiter_tb;
  import pia_pkg::*;
  logic ref_clk;
  logic nrst;
  logic [NUM_VEC-1:0] irq_req;
  pia_slot_t [NUM_SLOT-1:0] lvl1_slot;
  pia_slot_t [NUM_SLOT-1:0] lvl2_slot;
  logic [ADDR_W-1:0] vector_base;
  logic [LVL_W-1:0] core_level;
  logic [OPC_W-1:0] last_vec_opcode;
  pia_grant_t grant;
  int n_fail;
  int tests_run;
  localparam logic [NUM_VEC-1:0] ONE = 51'h1;

  pia_arbiter DUT (.ref_clk(ref_clk), .nrst(nrst), .irq_req(irq_req),
    .lvl1_slot(lvl1_slot), .lvl2_slot(lvl2_slot), .core_level(core_level),
    .vector_base(vector_base), .last_vec_opcode(last_vec_opcode),
    .grant(grant));
  pia_core_model core (.ref_clk(ref_clk), .grant(grant),
    .core_level(core_level), .last_vec_opcode(last_vec_opcode));

  // ==========================================
  // reference: level per source, top level, lowest vector at that level
  function automatic pia_grant_t expect_g();
    pia_grant_t g;
    logic [LVL_W-1:0] lv;
    int top;
    g = '0;
    top = -1;
    for (int v = 0; v < NUM_VEC; v++) begin
      lv = LVL0;
      for (int s = 0; s < NUM_SLOT; s++) begin
        if (lvl1_slot[s].en && lvl1_slot[s].vec == v) lv = LVL1;
      end
      // level 2 checked last so it wins for a source in both sets
      for (int s = 0; s < NUM_SLOT; s++) begin
        if (lvl2_slot[s].en && lvl2_slot[s].vec == v) lv = LVL2;
      end
      // strictly greater keeps the lowest vector within a level
      if (irq_req[v] && int'(lv) > top) begin
        top = int'(lv);
        g.vec = VEC_W'(v);
      end
    end
    if (top >= 0 && top >= int'(core_level)) begin
      g.pending = 1'b1;
      g.level = LVL_W'(top);
      g.addr = vector_base + {14'h0000, g.vec, 1'b0};
      g.fast = g.vec == LAST_USER_VECTOR
        && (last_vec_opcode & SUBROUTINE_JUMP_MASK) != SUBROUTINE_JUMP_OPCODE
        && (last_vec_opcode & SUBROUTINE_BRANCH_MASK)
           != SUBROUTINE_BRANCH_OPCODE;
    end
    else
      g = '0;
    return g;
  endfunction

  task automatic chk(input string what, input pia_grant_t e);
    tests_run++;
    if (grant !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, e, grant);
    end
  endtask

  task automatic chk_int(input string what, input int e, input int s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0d got %0d", what, e, s);
    end
  endtask

  // drive after an edge, then judge one cycle later (one-cycle latency)
  task automatic step(input logic [NUM_VEC-1:0] r,
      input logic [LVL_W-1:0] l, input logic [OPC_W-1:0] o,
      input string what);
    @(posedge ref_clk);
    #1;
    irq_req = r;
    core.set(l, o);
    @(posedge ref_clk);
    #1;
    chk(what, expect_g());
  endtask

  task automatic s_basic();
    int n0;
    n0 = core.n_taken;
    step(ONE << 5, LVL0, 16'h0000, "walk");
    chk("walk_lit", {2'b10, LVL0, 6'h05, vector_base + 21'h00000A});
    step('1, LVL0, 16'h0000, "all");
    step((ONE << 50) | (ONE << 49), LVL0, 16'h0000, "hi");
    step('0, LVL0, 16'h0000, "idle");
    // three busy steps of two cycles, seen by the core one edge late
    chk_int("taken", 6, core.n_taken - n0);
  endtask

  task automatic s_levels();
    lvl1_slot = {7'h14, 7'h6D, 7'h68}; // 20 off, 45, 40
    step((ONE << 2) | (ONE << 40) | (ONE << 45), LVL0, 0, "l1");
    step((ONE << 2) | (ONE << 20), LVL0, 0, "l1off");
    lvl2_slot = {7'h71, 7'h70, 7'h6D}; // 49, 48, 45
    step((ONE << 2) | (ONE << 40) | (ONE << 45), LVL0, 0, "l2");
    lvl2_slot[2] = 7'h68; // 40 in both sets
    step((ONE << 45) | (ONE << 40), LVL0, 0, "both");
  endtask

  task automatic s_mask();
    step(ONE << 20 | ONE << 3, LVL1, 0, "l0mask");
    step(ONE << 3 | ONE << 40, LVL2, 0, "hidden");
    step(ONE << 40, 2'h3, 0, "all_mask");
    step(ONE << 40, LVL2, 0, "accept");
  endtask

  task automatic s_fast();
    logic [OPC_W-1:0] opc [5] = '{16'h0000, 16'hE2FF, 16'hE440, 16'hE280,
      16'hE47F};
    foreach (opc[i]) step(ONE << 50, LVL0, opc[i], "fast");
  endtask

  task automatic s_reset();
    step(ONE << 7, LVL0, 0, "pre");
    // asynchronous entry: the grant must clear without a clock edge
    nrst = 1'b0;
    #1;
    chk("in_reset", '0);
    @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    step(ONE << 9, LVL0, 0, "post");
  endtask

  // ==========================================
  // one exit for both the normal end and the watchdog
  task automatic print_verdict();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    nrst = 1'b0;
    irq_req = '0;
    lvl1_slot = '0;
    lvl2_slot = '0;
    vector_base = 21'h001F00;
    repeat (2) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    s_basic();
    s_levels();
    s_mask();
    s_fast();
    s_reset();
    print_verdict();
  end
endmodule
